/* File: triple_timer_pkg.sv */
// Shared constants for the three-timer module: register map, fields, modes, timing
package triple_timer_pkg;
  // Register byte offsets (APB, one 32-bit word each)
  localparam logic [7:0] CORE_CTRL_OFF = 8'h00;
  localparam logic [7:0] AUXA_CTRL_OFF = 8'h04;
  localparam logic [7:0] AUXB_CTRL_OFF = 8'h08;
  localparam logic [7:0] CORE_CNT_OFF = 8'h0c;
  localparam logic [7:0] AUXA_CNT_OFF = 8'h10;
  localparam logic [7:0] AUXB_CNT_OFF = 8'h14;
  localparam logic [7:0] PRESCALE_OFF = 8'h18;
  localparam logic [7:0] IRQ_STATUS_OFF = 8'h1c;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h20;
  localparam logic [7:0] TOGGLE_OFF = 8'h24;
  // Control word fields
  localparam int MODE_LSB = 0;
  localparam int MODE_W = 2;
  localparam int RUN_BIT = 2;
  localparam int DOWN_BIT = 3;
  localparam int EXTDIR_BIT = 4;
  localparam int GATE_LVL_BIT = 5;
  localparam int EDGE_LSB = 6;
  localparam int EDGE_W = 2;
  localparam int SRC_TGL_BIT = 8;
  localparam int AUXF_LSB = 9;
  localparam int AUXF_W = 2;
  localparam int TGLOUT_EN_BIT = 11;
  localparam int CTRL_W = 12;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
  // Basic modes
  localparam logic [1:0] MODE_TIMER = 2'h0;
  localparam logic [1:0] MODE_COUNTER = 2'h1;
  localparam logic [1:0] MODE_GATED = 2'h2;
  localparam logic [1:0] MODE_INCR = 2'h3;
  // Auxiliary function select
  localparam logic [1:0] AUXF_NONE = 2'h0;
  localparam logic [1:0] AUXF_CAPTURE = 2'h1;
  localparam logic [1:0] AUXF_RELOAD = 2'h2;
  // Edge select: bit0 rising, bit1 falling (reload on toggle uses the same coding)
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  // Status bits: wrap per timer, capture for aux A and aux B only
  localparam int ST_CORE_WRAP = 0;
  localparam int ST_AUXA_WRAP = 1;
  localparam int ST_AUXB_WRAP = 2;
  localparam int ST_AUXA_CAP = 3;
  localparam int ST_AUXB_CAP = 4;
  localparam int ST_W = 5;
  // Timing: CPU state time unit is half a clock period; base rate is 16 of them
  localparam int STATE_UNITS_PER_CYCLE = 2;
  localparam int MIN_RES_UNITS = 16;
  localparam int BASE_DIV = MIN_RES_UNITS / STATE_UNITS_PER_CYCLE;
  localparam int PRESC_W = 3;
  localparam logic [PRESC_W-1:0] PRESC_RESET = 3'h0;
endpackage

/* File: triple_timer_module.sv */
// Three 16-bit timers (core plus two auxiliaries) with APB registers and one interrupt
// How it works
// - three 16-bit timers, core and two auxiliaries
// - each timer picks one of four modes
// - timer mode counts prescaled system clock
// - counter mode counts input pin edges
// - gated mode runs while pin at gate level
// - one input pin per timer, gate or clock
// - finest resolution is sixteen state time units
// - direction by software, optionally by pin
// - quadrature tracks on input and direction pins
// - core toggle latch flips on every wrap
// - toggle latch drives pin and clocks auxiliaries
// - auxiliaries as capture or reload stop counting
// - capture copies core count on pin edge
// - reload from pin or toggle transition
// - alternate reloads on opposite toggle edges give PWM
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
module triple_timer_module #(
  parameter int CNT_W = 16
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [2:0] timer_input_pin_i,
  input wire logic [2:0] direction_input_pin_i,
  output logic toggle_output_pin_o,
  output logic irq_o
);
  // Index 0 core, 1 aux A, 2 aux B
  localparam int N = 3;

  initial begin
    if (CNT_W != 16) begin
      $error("Counter width must be 16");
    end
  end

  localparam int CTRL_W_L = triple_timer_pkg::CTRL_W;
  logic [CTRL_W_L-1:0] ctrl_reg [N];
  logic [CNT_W-1:0] cnt_reg [N];
  logic [triple_timer_pkg::PRESC_W-1:0] presc_reg;
  logic [triple_timer_pkg::ST_W-1:0] status_reg;
  logic [triple_timer_pkg::ST_W-1:0] mask_reg;
  logic core_toggle_latch_reg;
  logic [2:0] in_s1_reg, in_s2_reg, in_d_reg;
  logic [2:0] dir_s1_reg, dir_s2_reg, dir_d_reg;
  logic [15:0] base_cnt_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  logic toggle_pin_reg;

  // Base tick every 8 clocks (16 state time units); prescaler multiplies by 2^n
  wire [15:0] presc_limit = 16'((triple_timer_pkg::BASE_DIV << presc_reg) - 1);
  wire base_tick = (base_cnt_reg == presc_limit);

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      base_cnt_reg <= 16'h0000;
    end else begin
      base_cnt_reg <= base_tick ? 16'h0000 : 16'(base_cnt_reg + 16'h0001);
    end
  end

  // Two-flop synchronisers; the third stage gives edge history
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      in_s1_reg <= 3'h0;
      in_s2_reg <= 3'h0;
      in_d_reg <= 3'h0;
      dir_s1_reg <= 3'h0;
      dir_s2_reg <= 3'h0;
      dir_d_reg <= 3'h0;
    end else begin
      in_s1_reg <= timer_input_pin_i;
      in_s2_reg <= in_s1_reg;
      in_d_reg <= in_s2_reg;
      dir_s1_reg <= direction_input_pin_i;
      dir_s2_reg <= dir_s1_reg;
      dir_d_reg <= dir_s2_reg;
    end
  end

  // APB decode
  wire access = psel_i && penable_i;
  wire addr_ok = (paddr_i[1:0] == 2'h0) && (paddr_i <= triple_timer_pkg::TOGGLE_OFF);
  // Writes that get an error reply must not alias onto a register through widx
  wire wr_en = access && pwrite_i && addr_ok;
  wire [3:0] widx = paddr_i[5:2];
  wire wr_status = wr_en && paddr_i == triple_timer_pkg::IRQ_STATUS_OFF;

  // Toggle latch edges from the previous cycle, used for reload and aux clocking
  logic tgl_prev_reg;
  wire tgl_rise = core_toggle_latch_reg && !tgl_prev_reg;
  wire tgl_fall = !core_toggle_latch_reg && tgl_prev_reg;

  logic [N-1:0] step, down, wrap, cap_ev, reload_ev;
  logic [N-1:0] is_aux_fn;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_timer
      wire [1:0] mode = ctrl_reg[g][triple_timer_pkg::MODE_LSB +: triple_timer_pkg::MODE_W];
      wire run = ctrl_reg[g][triple_timer_pkg::RUN_BIT];
      wire [1:0] esel = ctrl_reg[g][triple_timer_pkg::EDGE_LSB +: triple_timer_pkg::EDGE_W];
      wire [1:0] auxf = ctrl_reg[g][triple_timer_pkg::AUXF_LSB +: triple_timer_pkg::AUXF_W];
      wire pin_rise = in_s2_reg[g] && !in_d_reg[g];
      wire pin_fall = !in_s2_reg[g] && in_d_reg[g];
      wire pin_edge = (pin_rise && esel[triple_timer_pkg::EDGE_RISE_BIT])
                   || (pin_fall && esel[triple_timer_pkg::EDGE_FALL_BIT]);
      wire tgl_edge = (tgl_rise && esel[triple_timer_pkg::EDGE_RISE_BIT])
                   || (tgl_fall && esel[triple_timer_pkg::EDGE_FALL_BIT]);
      // Aux timers may count toggle latch transitions instead of their pin
      wire use_tgl = (g != 0) && ctrl_reg[g][triple_timer_pkg::SRC_TGL_BIT];
      wire cnt_edge = use_tgl ? tgl_edge : pin_edge;
      wire gate_ok = in_s2_reg[g] == ctrl_reg[g][triple_timer_pkg::GATE_LVL_BIT];
      // Quadrature: any edge on either track steps, direction from A xor B history
      wire a_chg = in_s2_reg[g] ^ in_d_reg[g];
      wire b_chg = dir_s2_reg[g] ^ dir_d_reg[g];
      wire quad_dn = a_chg ? (in_s2_reg[g] == dir_s2_reg[g])
                           : (in_s2_reg[g] != dir_s2_reg[g]);
      wire ext_dir = ctrl_reg[g][triple_timer_pkg::EXTDIR_BIT] && dir_s2_reg[g];
      assign is_aux_fn[g] = (g != 0) && (auxf != triple_timer_pkg::AUXF_NONE);
      always_comb begin
        step[g] = 1'b0;
        down[g] = ctrl_reg[g][triple_timer_pkg::DOWN_BIT] ^ ext_dir;
        unique case (mode)
          triple_timer_pkg::MODE_TIMER: step[g] = base_tick;
          triple_timer_pkg::MODE_COUNTER: step[g] = cnt_edge;
          triple_timer_pkg::MODE_GATED: step[g] = base_tick && gate_ok;
          triple_timer_pkg::MODE_INCR: begin
            step[g] = a_chg || b_chg;
            down[g] = quad_dn ^ ctrl_reg[g][triple_timer_pkg::DOWN_BIT];
          end
        endcase
        // Capture or reload use halts the aux count
        if (!run || is_aux_fn[g]) begin
          step[g] = 1'b0;
        end
      end
      assign wrap[g] = step[g] && (down[g] ? (cnt_reg[g] == '0) : (&cnt_reg[g]));
      assign cap_ev[g] = (g != 0) && auxf == triple_timer_pkg::AUXF_CAPTURE && pin_edge;
      // Reload triggers on the pin, or on toggle edges when the toggle source is picked
      assign reload_ev[g] = (g != 0) && auxf == triple_timer_pkg::AUXF_RELOAD
                         && (use_tgl ? tgl_edge : pin_edge);
    end
  endgenerate

  // Aux A wins if both auxes reload at once; the PWM pairing uses opposite edges
  wire [CNT_W-1:0] reload_val = reload_ev[1] ? cnt_reg[1] : cnt_reg[2];

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < N; i++) begin
        cnt_reg[i] <= '0;
        ctrl_reg[i] <= triple_timer_pkg::CTRL_RESET;
      end
      presc_reg <= triple_timer_pkg::PRESC_RESET;
      mask_reg <= '0;
      core_toggle_latch_reg <= 1'b0;
      tgl_prev_reg <= 1'b0;
    end else begin
      tgl_prev_reg <= core_toggle_latch_reg;
      if (wrap[0]) begin
        core_toggle_latch_reg <= !core_toggle_latch_reg;
      end else if (wr_en && paddr_i == triple_timer_pkg::TOGGLE_OFF) begin
        core_toggle_latch_reg <= pwdata_i[0];
      end
      for (int i = 0; i < N; i++) begin
        if (step[i]) begin
          cnt_reg[i] <= down[i] ? CNT_W'(cnt_reg[i] - 1'b1)
                                : CNT_W'(cnt_reg[i] + 1'b1);
        end
        if (cap_ev[i]) begin
          cnt_reg[i] <= cnt_reg[0];
        end
        if (wr_en && widx == 4'(i)) begin
          ctrl_reg[i] <= pwdata_i[CTRL_W_L-1:0];
        end
        if (wr_en && widx == 4'(i + 3)) begin
          cnt_reg[i] <= pwdata_i[CNT_W-1:0];
        end
      end
      if (reload_ev[1] || reload_ev[2]) begin
        cnt_reg[0] <= reload_val;
      end
      if (wr_en && paddr_i == triple_timer_pkg::PRESCALE_OFF) begin
        presc_reg <= pwdata_i[triple_timer_pkg::PRESC_W-1:0];
      end
      if (wr_en && paddr_i == triple_timer_pkg::IRQ_MASK_OFF) begin
        mask_reg <= pwdata_i[triple_timer_pkg::ST_W-1:0];
      end
    end
  end

  // Service flags: set wins over a write-one clear in the same cycle
  wire [triple_timer_pkg::ST_W-1:0] st_set = {cap_ev[2], cap_ev[1], wrap};
  wire [triple_timer_pkg::ST_W-1:0] st_clr = wr_status
                                           ? pwdata_i[triple_timer_pkg::ST_W-1:0] : '0;
  wire [triple_timer_pkg::ST_W-1:0] status_next = (status_reg & ~st_clr) | st_set;

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      status_reg <= '0;
      irq_reg <= 1'b0;
      toggle_pin_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= |(status_next & mask_reg);
      toggle_pin_reg <= core_toggle_latch_reg
                     && ctrl_reg[0][triple_timer_pkg::TGLOUT_EN_BIT];
    end
  end

  // Read mux; single-cycle access phase, error on unmapped or unaligned address
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (paddr_i)
      triple_timer_pkg::CORE_CTRL_OFF: rd_mux = 32'(ctrl_reg[0]);
      triple_timer_pkg::AUXA_CTRL_OFF: rd_mux = 32'(ctrl_reg[1]);
      triple_timer_pkg::AUXB_CTRL_OFF: rd_mux = 32'(ctrl_reg[2]);
      triple_timer_pkg::CORE_CNT_OFF: rd_mux = 32'(cnt_reg[0]);
      triple_timer_pkg::AUXA_CNT_OFF: rd_mux = 32'(cnt_reg[1]);
      triple_timer_pkg::AUXB_CNT_OFF: rd_mux = 32'(cnt_reg[2]);
      triple_timer_pkg::PRESCALE_OFF: rd_mux = 32'(presc_reg);
      triple_timer_pkg::IRQ_STATUS_OFF: rd_mux = 32'(status_reg);
      triple_timer_pkg::IRQ_MASK_OFF: rd_mux = 32'(mask_reg);
      triple_timer_pkg::TOGGLE_OFF: rd_mux = 32'(core_toggle_latch_reg);
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel_i && !penable_i;
      pslverr_reg <= psel_i && !penable_i && !addr_ok;
      if (psel_i && !penable_i && !pwrite_i) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign irq_o = irq_reg;
  assign toggle_output_pin_o = toggle_pin_reg;

  // Register writes and reloads win over a step, so wrap checks leave those cycles out

  AST_WRAP_TOGGLES: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wrap[0] |=> core_toggle_latch_reg != $past(core_toggle_latch_reg))
    else $error("Toggle latch did not flip on core wrap");
  AST_TGL_ONLY_WRAP: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    core_toggle_latch_reg != $past(core_toggle_latch_reg)
    |-> $past(wrap[0]) || $past(wr_en && paddr_i == triple_timer_pkg::TOGGLE_OFF))
    else $error("Toggle latch changed without wrap or write");

  AST_UP_WRAP_ZERO: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (step[0] && !down[0] && &cnt_reg[0] && !reload_ev[1] && !reload_ev[2]
     && !(wr_en && widx == 4'h3)) |=> cnt_reg[0] == '0)
    else $error("Core did not wrap to zero");
  AST_DOWN_WRAP: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (step[0] && down[0] && cnt_reg[0] == '0 && !reload_ev[1] && !reload_ev[2]
     && !(wr_en && widx == 4'h3)) |=> &cnt_reg[0])
    else $error("Core did not wrap to all ones");
  AST_AUX_STEP_ONE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (step[1] && !down[1] && !(wr_en && widx == 4'h4))
    |=> cnt_reg[1] == CNT_W'($past(cnt_reg[1]) + 1'b1))
    else $error("Aux A did not advance by one");
  AST_DOWN_STEP_ONE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (step[1] && down[1] && !(wr_en && widx == 4'h4))
    |=> cnt_reg[1] == CNT_W'($past(cnt_reg[1]) - 1'b1))
    else $error("Aux A did not go back by one");

  AST_RUN_OFF_CORE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !gen_timer[0].run |-> !step[0])
    else $error("Core stepped while stopped");
  AST_RUN_OFF: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !gen_timer[2].run |-> !step[2])
    else $error("Aux B stepped while stopped");
  AST_AUX_STOPPED: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    is_aux_fn[1] |-> !step[1])
    else $error("Aux A counts while used as capture or reload");
  AST_AUXB_STOPPED: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    is_aux_fn[2] |-> !step[2])
    else $error("Aux B counts while used as capture or reload");
  AST_RELOAD_HOLD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (reload_ev[2] && !(wr_en && widx == 4'h5))
    |=> cnt_reg[2] == $past(cnt_reg[2]))
    else $error("Aux B changed while used as reload");
  AST_CAPTURE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (cap_ev[1] && !(wr_en && widx == 4'h4)) |=> cnt_reg[1] == $past(cnt_reg[0]))
    else $error("Capture did not copy core count");
  AST_CAPTURE_B: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (cap_ev[2] && !(wr_en && widx == 4'h5)) |=> cnt_reg[2] == $past(cnt_reg[0]))
    else $error("Capture into aux B did not copy core count");
  AST_RELOAD: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (reload_ev[2] && !reload_ev[1] && !(wr_en && widx == 4'h3))
    |=> cnt_reg[0] == $past(cnt_reg[2]))
    else $error("Reload from aux B missing");
  AST_RELOAD_A: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (reload_ev[1] && !(wr_en && widx == 4'h3)) |=> cnt_reg[0] == $past(cnt_reg[1]))
    else $error("Reload from aux A missing");

  AST_FLAG_SET: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wrap[0] |=> status_reg[triple_timer_pkg::ST_CORE_WRAP])
    else $error("Wrap flag not set");
  AST_FLAG_WRAP_B: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    wrap[2] |=> status_reg[triple_timer_pkg::ST_AUXB_WRAP])
    else $error("Aux B wrap flag not set");
  AST_FLAG_CAP: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cap_ev[1] |=> status_reg[triple_timer_pkg::ST_AUXA_CAP])
    else $error("Capture flag not set");
  AST_IRQ: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    $rose(status_reg[0]) && $past(mask_reg[0]) |-> irq_o)
    else $error("Unmasked flag gave no interrupt");
  AST_IRQ_QUIET: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (status_reg & mask_reg) == '0 && $stable(mask_reg) |-> !irq_o)
    else $error("Interrupt without an unmasked flag");

  AST_TIMER_RATE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    base_tick && presc_reg == 3'h0 |=> !base_tick [*7])
    else $error("Base tick faster than eight cycles");
  AST_TIMER_TICK: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (gen_timer[0].mode == triple_timer_pkg::MODE_TIMER && gen_timer[0].run)
    |-> step[0] == base_tick)
    else $error("Timer mode did not follow the prescaled tick");
  AST_COUNTER_EDGE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (gen_timer[0].mode == triple_timer_pkg::MODE_COUNTER && gen_timer[0].run)
    |-> step[0] == gen_timer[0].pin_edge)
    else $error("Counter mode did not follow pin edges");
  AST_GATE_CLOSED: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ctrl_reg[0][1:0] == triple_timer_pkg::MODE_GATED
     && in_s2_reg[0] != ctrl_reg[0][triple_timer_pkg::GATE_LVL_BIT]) |-> !step[0])
    else $error("Gated timer ran with gate closed");
  AST_GATE_OPEN: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (gen_timer[0].mode == triple_timer_pkg::MODE_GATED && gen_timer[0].run
     && gen_timer[0].gate_ok) |-> step[0] == base_tick)
    else $error("Gated timer missed a tick with gate open");
  AST_EXT_DIR: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (gen_timer[0].mode != triple_timer_pkg::MODE_INCR
     && ctrl_reg[0][triple_timer_pkg::EXTDIR_BIT] && dir_s2_reg[0])
    |-> down[0] != ctrl_reg[0][triple_timer_pkg::DOWN_BIT])
    else $error("Direction pin did not invert the count");
  AST_QUAD_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (gen_timer[2].mode == triple_timer_pkg::MODE_INCR && in_s2_reg[2] == in_d_reg[2]
     && dir_s2_reg[2] == dir_d_reg[2]) |-> !step[2])
    else $error("Quadrature stepped with no track edge");
  AST_AUX_TGL_CLOCK: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (gen_timer[1].mode == triple_timer_pkg::MODE_COUNTER && gen_timer[1].run
     && gen_timer[1].use_tgl && !is_aux_fn[1]) |-> step[1] == gen_timer[1].tgl_edge)
    else $error("Aux A did not count toggle latch edges");
  AST_TGL_PIN_OFF: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !ctrl_reg[0][triple_timer_pkg::TGLOUT_EN_BIT] |=> !toggle_output_pin_o)
    else $error("Toggle pin driven while disabled");
endmodule

/* File: pin_source.sv */
// Far-side model: event sources, gate levels and a quadrature encoder on the pins
`timescale 1ns/10ps
module pin_source (
  input wire logic clk_sys_i,
  output logic [2:0] timer_input_pin_o,
  output logic [2:0] direction_input_pin_o
);
  initial begin
    timer_input_pin_o = 3'h0;
    direction_input_pin_o = 3'h0;
  end
  // Index track is left out: it belongs on a separate interrupt input
  // Each level stands at least five clocks so two-flop sampling never drops a step
  task automatic set_pins(input int idx, input logic [1:0] lvl);
    @(posedge clk_sys_i);
    timer_input_pin_o[idx] <= lvl[0];
    direction_input_pin_o[idx] <= lvl[1];
    repeat (4) @(posedge clk_sys_i);
  endtask
  task automatic pulse(input int idx);
    set_pins(idx, {direction_input_pin_o[idx], 1'b1});
    set_pins(idx, {direction_input_pin_o[idx], 1'b0});
  endtask
  // Gray walk of tracks A and B, forward or backward from 00
  task automatic quad(input int idx, input logic back);
    logic [1:0] fwd [4];
    logic [1:0] rev [4];
    fwd = '{2'h1, 2'h3, 2'h2, 2'h0};
    rev = '{2'h2, 2'h3, 2'h1, 2'h0};
    for (int i = 0; i < 4; i++) begin
      set_pins(idx, back ? rev[i] : fwd[i]);
    end
  endtask
endmodule

/* File: testbench.sv */
// Self-checking bench: APB register access and pin-driven timer scenarios
`timescale 1ns/10ps
`define CHECK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("unexpected %s expected %h seen %h", what, exp, got); \
    end \
  end
module testbench;
  localparam logic [31:0] RUN = 32'h1 << triple_timer_pkg::RUN_BIT;
  localparam logic [31:0] EXTDIR = 32'h1 << triple_timer_pkg::EXTDIR_BIT;
  localparam logic [31:0] GATE_HI = 32'h1 << triple_timer_pkg::GATE_LVL_BIT;
  localparam logic [31:0] RISE = 32'h1 << triple_timer_pkg::EDGE_LSB;
  localparam logic [31:0] TGLOUT = 32'h1 << triple_timer_pkg::TGLOUT_EN_BIT;
  localparam logic [31:0] DOWN = 32'h1 << triple_timer_pkg::DOWN_BIT;
  localparam logic [31:0] SRC = 32'h1 << triple_timer_pkg::SRC_TGL_BIT;
  localparam logic [31:0] FALL = 32'h1 << (triple_timer_pkg::EDGE_LSB
    + triple_timer_pkg::EDGE_FALL_BIT);
  localparam logic [31:0] CAP = 32'(triple_timer_pkg::AUXF_CAPTURE) << triple_timer_pkg::AUXF_LSB;
  localparam logic [31:0] RLD = 32'(triple_timer_pkg::AUXF_RELOAD) << triple_timer_pkg::AUXF_LSB;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic [2:0] timer_input_pin_i;
  logic [2:0] direction_input_pin_i;
  logic toggle_output_pin_o;
  logic irq_o;
  logic [31:0] rd;
  logic err;
  int fails = 0;
  int samples_checked = 0;
  always #12.5 clk_sys_i = ~clk_sys_i;
  triple_timer_module triple_timer_module_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .timer_input_pin_i(timer_input_pin_i), .direction_input_pin_i(direction_input_pin_i),
    .toggle_output_pin_o(toggle_output_pin_o), .irq_o(irq_o));
  pin_source pin_source_inst (.clk_sys_i(clk_sys_i), .timer_input_pin_o(timer_input_pin_i),
    .direction_input_pin_o(direction_input_pin_i));
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= addr;
    pwdata_i <= wdata;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_sys_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    xfer(1'b1, addr, data);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
    xfer(1'b0, addr, 32'h0);
    `CHECK(what, exp, rd)
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    fails++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    rd_chk("core ctrl", triple_timer_pkg::CORE_CTRL_OFF, 32'h0);
    rd_chk("status", triple_timer_pkg::IRQ_STATUS_OFF, 32'h0);
    rd_chk("unmapped", 8'h28, 32'h0);
    `CHECK("unmapped err", 1'b1, err)
    wr(triple_timer_pkg::AUXB_CNT_OFF, 32'hffffffff);
    rd_chk("count width", triple_timer_pkg::AUXB_CNT_OFF, 32'h0000ffff);
    $display("test map done");
    wr(triple_timer_pkg::IRQ_MASK_OFF, 32'h1);
    wr(triple_timer_pkg::CORE_CNT_OFF, 32'h0000ffff);
    wr(triple_timer_pkg::CORE_CTRL_OFF, 32'(triple_timer_pkg::MODE_COUNTER) | RUN | RISE
      | EXTDIR | TGLOUT);
    pin_source_inst.pulse(0);
    rd_chk("wrap up", triple_timer_pkg::CORE_CNT_OFF, 32'h0);
    rd_chk("latch set", triple_timer_pkg::TOGGLE_OFF, 32'h1);
    `CHECK("toggle pin", 1'b1, toggle_output_pin_o)
    `CHECK("irq on", 1'b1, irq_o)
    wr(triple_timer_pkg::IRQ_STATUS_OFF, 32'h1);
    repeat (3) @(posedge clk_sys_i);
    `CHECK("irq cleared", 1'b0, irq_o)
    wr(triple_timer_pkg::IRQ_MASK_OFF, 32'h0);
    pin_source_inst.set_pins(0, 2'h2);
    pin_source_inst.pulse(0);
    rd_chk("wrap down", triple_timer_pkg::CORE_CNT_OFF, 32'h0000ffff);
    rd_chk("latch clear", triple_timer_pkg::TOGGLE_OFF, 32'h0);
    `CHECK("toggle pin low", 1'b0, toggle_output_pin_o)
    rd_chk("wrap flag", triple_timer_pkg::IRQ_STATUS_OFF, 32'h1);
    `CHECK("irq masked", 1'b0, irq_o)
    pin_source_inst.set_pins(0, 2'h0);
    wr(triple_timer_pkg::CORE_CTRL_OFF, 32'h0);
    wr(triple_timer_pkg::IRQ_STATUS_OFF, 32'h1f);
    $display("test wrap done");
    wr(triple_timer_pkg::CORE_CNT_OFF, 32'h1234);
    wr(triple_timer_pkg::AUXA_CTRL_OFF, CAP | RISE | RUN);
    pin_source_inst.pulse(1);
    repeat (40) @(posedge clk_sys_i);
    rd_chk("capture", triple_timer_pkg::AUXA_CNT_OFF, 32'h1234);
    rd_chk("cap flag", triple_timer_pkg::IRQ_STATUS_OFF, 32'h8);
    wr(triple_timer_pkg::AUXB_CNT_OFF, 32'h00aa);
    wr(triple_timer_pkg::AUXB_CTRL_OFF, RLD | RISE);
    pin_source_inst.pulse(2);
    rd_chk("reload", triple_timer_pkg::CORE_CNT_OFF, 32'h00aa);
    wr(triple_timer_pkg::AUXB_CTRL_OFF, 32'h0);
    $display("test capture_reload done");
    // Prescaler 0 is the finest step; both settings should give about ten ticks
    for (int p = 0; p < 2; p++) begin
      wr(triple_timer_pkg::AUXB_CNT_OFF, 32'h0);
      wr(triple_timer_pkg::PRESCALE_OFF, 32'(p));
      wr(triple_timer_pkg::AUXB_CTRL_OFF, RUN);
      repeat (80 << p) @(posedge clk_sys_i);
      wr(triple_timer_pkg::AUXB_CTRL_OFF, 32'h0);
      xfer(1'b0, triple_timer_pkg::AUXB_CNT_OFF, 32'h0);
      `CHECK("timer ticks", 1'b1, rd >= 32'h9 && rd <= 32'hb)
    end
    wr(triple_timer_pkg::CORE_CNT_OFF, 32'h0);
    wr(triple_timer_pkg::CORE_CTRL_OFF, 32'(triple_timer_pkg::MODE_GATED) | RUN | GATE_HI);
    repeat (80) @(posedge clk_sys_i);
    rd_chk("gate closed", triple_timer_pkg::CORE_CNT_OFF, 32'h0);
    pin_source_inst.set_pins(0, 2'h1);
    repeat (156) @(posedge clk_sys_i);
    pin_source_inst.set_pins(0, 2'h0);
    xfer(1'b0, triple_timer_pkg::CORE_CNT_OFF, 32'h0);
    `CHECK("gate open", 1'b1, rd >= 32'h9 && rd <= 32'hc)
    $display("test prescale_gate done");
    wr(triple_timer_pkg::AUXB_CNT_OFF, 32'h0);
    wr(triple_timer_pkg::AUXB_CTRL_OFF, 32'(triple_timer_pkg::MODE_INCR) | RUN);
    pin_source_inst.quad(2, 1'b0);
    rd_chk("quad forward", triple_timer_pkg::AUXB_CNT_OFF, 32'h4);
    pin_source_inst.quad(2, 1'b1);
    rd_chk("quad back", triple_timer_pkg::AUXB_CNT_OFF, 32'h0);
    $display("test quadrature done");
    wr(triple_timer_pkg::AUXA_CNT_OFF, 32'h0010);
    wr(triple_timer_pkg::AUXB_CNT_OFF, 32'h0020);
    wr(triple_timer_pkg::AUXA_CTRL_OFF, RLD | RISE | SRC);
    wr(triple_timer_pkg::AUXB_CTRL_OFF, RLD | FALL | SRC);
    wr(triple_timer_pkg::CORE_CNT_OFF, 32'h0000ffff);
    wr(triple_timer_pkg::CORE_CTRL_OFF, 32'(triple_timer_pkg::MODE_COUNTER) | RUN | RISE);
    pin_source_inst.pulse(0);
    rd_chk("pwm high", triple_timer_pkg::CORE_CNT_OFF, 32'h0010);
    wr(triple_timer_pkg::CORE_CNT_OFF, 32'h0);
    wr(triple_timer_pkg::CORE_CTRL_OFF, 32'(triple_timer_pkg::MODE_COUNTER) | RUN | RISE
      | DOWN);
    pin_source_inst.pulse(0);
    rd_chk("pwm low", triple_timer_pkg::CORE_CNT_OFF, 32'h0020);
    $display("test pwm done");
    report_and_stop();
  end
endmodule
